// *** hdl/phy_aux_pkg.sv ***
// Package: register map, field positions, reset values and framing constants
package phy_aux_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [4:0] REG_AUX_MODE_LED_TXGAP = 5'h1D;
  localparam logic [4:0] REG_AUX_MULTI_PHY_STATUS_CTRL = 5'h1E;
  localparam logic [4:0] REG_TEST_SHADOW_ENABLE = 5'h1F;
  localparam logic [4:0] SHADOW_ADDR_LO = 5'h1A;
  localparam logic [4:0] SHADOW_ADDR_HI = 5'h1E;

  // ==========================================================
  // Auxiliary mode fields
  localparam int MODE_ACT_DIS_BIT = 4;
  localparam int MODE_LINK_DIS_BIT = 3;
  localparam int MODE_GAP_BIT = 1;

  // ==========================================================
  // Aux_multi_phy_status_ctrl fields
  localparam int MULTI_RESULT_HI = 15;
  localparam int MULTI_RESULT_LO = 11;
  localparam int MULTI_RESTART_BIT = 8;
  localparam int MULTI_COMPLETE_BIT = 7;
  localparam int MULTI_ACK_DONE_BIT = 6;
  localparam int MULTI_ACK_SEEN_BIT = 5;
  localparam int MULTI_ABILITY_BIT = 4;
  localparam int MULTI_ISOLATE_BIT = 3;
  localparam int MULTI_SERIAL_BIT = 1;

  // Positions inside the five-bit negotiated result field
  localparam int RESULT_FAST_TX_FULL_DUPLEX = 4;
  localparam int RESULT_FAST_FOUR_PAIR = 3;
  localparam int RESULT_FAST_TX_HALF = 2;
  localparam int RESULT_TEN_FULL_DUPLEX = 1;
  localparam int RESULT_TEN_HALF = 0;

  // ==========================================================
  // Test register
  localparam int TEST_SHADOW_BIT = 7;
  localparam logic [15:0] TEST_RESET = 16'h000B;

  // ==========================================================
  // Management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] DATA_LAST = 6'h0F;

  // ==========================================================
  // Short inter-packet gap window, in transmit clock cycles
  localparam logic [2:0] GAP_MIN = 3'h1;
  localparam logic [2:0] GAP_MAX = 3'h4;

  typedef enum logic [3:0] {
    ST_PRE  = 4'h1,
    ST_HDR  = 4'h2,
    ST_TA   = 4'h4,
    ST_DATA = 4'h8
  } mgmt_state_t;

endpackage

// *** hdl/mgmt_serial_slave.sv ***
// Serial management frame slave: pin synchronisers, frame decode, read and write strobes
module mgmt_serial_slave
  import phy_aux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Station address
  input wire logic [4:0] phy_addr,
  // Register side
  output logic [4:0] reg_addr,
  output logic [15:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [15:0] rd_data
);

  // ==========================================================
  // Synchronisers: a level counts once stages two and three agree
  logic [2:0] mdc_ff_q;
  logic [2:0] mdio_ff_q;
  logic mdc_s_q;
  logic mdio_s_q;
  logic mdc_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_ff_q <= 3'h0;
      mdio_ff_q <= 3'h7;
      mdc_s_q <= 1'b0;
      mdio_s_q <= 1'b1;
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_ff_q <= {mdc_ff_q[1:0], mdc};
      mdio_ff_q <= {mdio_ff_q[1:0], mdio_i};
      if (mdc_ff_q[2] == mdc_ff_q[1]) begin
        mdc_s_q <= mdc_ff_q[2];
      end
      if (mdio_ff_q[2] == mdio_ff_q[1]) begin
        mdio_s_q <= mdio_ff_q[2];
      end
      mdc_prev_q <= mdc_s_q;
    end
  end

  wire rise = mdc_s_q & ~mdc_prev_q;
  wire fall = ~mdc_s_q & mdc_prev_q;

  // ==========================================================
  // Frame decoder
  mgmt_state_t state_q;
  logic [5:0] cnt_q;
  logic [13:0] sh_q;
  logic [15:0] tx_q;
  logic read_q;
  logic [4:0] addr_q;
  logic [15:0] wd_q;
  logic wr_q;
  logic rd_q;
  logic out_q;
  logic oe_q;

  wire [13:0] hdr_w = {sh_q[12:0], mdio_s_q};
  wire hdr_ok = (hdr_w[13:12] == FRAME_START) && (hdr_w[9:5] == phy_addr) &&
                ((hdr_w[11:10] == OP_READ) || (hdr_w[11:10] == OP_WRITE));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_PRE;
      cnt_q <= 6'h00;
      sh_q <= 14'h0000;
      tx_q <= 16'h0000;
      read_q <= 1'b0;
      addr_q <= 5'h00;
      wd_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      out_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (rd_q) begin
        tx_q <= rd_data;
      end
      unique case (state_q)
        ST_PRE: begin
          if (fall) begin
            oe_q <= 1'b0;
          end
          if (rise) begin
            if (mdio_s_q) begin
              cnt_q <= (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
            end else if (cnt_q == PREAMBLE_LEN) begin
              sh_q <= 14'h0000;
              cnt_q <= 6'h00;
              state_q <= ST_HDR;
            end else begin
              cnt_q <= 6'h00;
            end
          end
        end
        ST_HDR: begin
          if (rise) begin
            sh_q <= hdr_w;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == HDR_LAST) begin
              cnt_q <= 6'h00;
              state_q <= hdr_ok ? ST_TA : ST_PRE;
              // Frames for another station are dropped and need a fresh preamble
              read_q <= (hdr_w[11:10] == OP_READ);
              addr_q <= hdr_w[4:0];
              rd_q <= hdr_ok && (hdr_w[11:10] == OP_READ);
            end
          end
        end
        ST_TA: begin
          if (rise) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q != 6'h00) begin
              cnt_q <= 6'h00;
              state_q <= ST_DATA;
            end
          end
          if (fall && read_q && (cnt_q != 6'h00)) begin
            oe_q <= 1'b1;
            out_q <= 1'b0;
          end
        end
        ST_DATA: begin
          if (fall && read_q) begin
            out_q <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
          end
          if (rise) begin
            wd_q <= {wd_q[14:0], mdio_s_q};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == DATA_LAST) begin
              cnt_q <= 6'h00;
              wr_q <= ~read_q;
              state_q <= ST_PRE;
            end
          end
        end
      endcase
    end
  end

  assign mdio_o = out_q;
  assign mdio_oe = oe_q;
  assign reg_addr = addr_q;
  assign wr_data = wd_q;
  assign wr_stb = wr_q;
  assign rd_stb = rd_q;

endmodule

// *** hdl/phy_aux_control_status_regs.sv ***
// Auxiliary control and status registers with management access and datapath gating
module phy_aux_control_status_regs
  import phy_aux_pkg::*;
#(
  parameter logic [4:0] PHY_ADDRESS = 5'h01
)(
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // Management pins
  input wire logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE,
  // Registers kept elsewhere, including the shadow bank
  output logic EXT_WR,
  output logic EXT_RD,
  output logic EXT_SHADOW,
  output logic [4:0] EXT_ADDR,
  output logic [15:0] EXT_WDATA,
  input wire logic [15:0] EXT_RDATA,
  // Negotiation engine
  input wire logic NEGOTIATION_ENABLE_PIN,
  input wire logic CTRL_AN_ENABLE,
  input wire logic CTRL_RESTART,
  input wire logic ABILITY_DETECT_STATE,
  input wire logic ACK_DETECT_EXIT,
  input wire logic COMPLETE_ACK_EXIT,
  input wire logic AN_DONE,
  input wire logic LINK_FAULT,
  input wire logic RESULT_VALID,
  input wire logic [4:0] RESULT_MODE,
  output logic AN_ENABLED,
  output logic AN_RESTART,
  // Indicators
  input wire logic TX_ACTIVITY,
  input wire logic RX_ACTIVITY,
  input wire logic LINK_UP,
  output logic TRANSMIT_ACTIVITY_INDICATOR_N,
  output logic RECEIVE_ACTIVITY_INDICATOR_N,
  output logic LINK_INDICATOR_N,
  // RMII datapath
  input wire logic SPEED_100,
  input wire logic TX_EN_IN,
  input wire logic [1:0] TXD_IN,
  output logic TX_EN_CORE,
  output logic [1:0] TXD_CORE,
  input wire logic CRS_DV_CORE,
  input wire logic [1:0] RXD_CORE,
  output logic CRS_DV_O,
  output logic [1:0] RXD_O,
  output logic RMII_OE,
  output logic SERIAL_ACTIVE,
  output logic INSERT_IDLES,
  output logic LINK_PULSE_EN
);

  // ==========================================================
  // Decoding helpers
  function automatic logic in_shadow(input logic [4:0] a);
    in_shadow = (a >= SHADOW_ADDR_LO) && (a <= SHADOW_ADDR_HI);
  endfunction

  // Highest-priority ability only, so one pass never adds two bits
  function automatic logic [4:0] top_result(input logic [4:0] m);
    top_result = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (m[i]) begin
        top_result = 5'h01 << i;
      end
    end
  endfunction

  // ==========================================================
  // Management access
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rd_data;

  mgmt_serial_slave u_slave (
    .clk(MCLK),
    .rst_n(NRST),
    .mdc(MDC),
    .mdio_i(MDIO_I),
    .mdio_o(MDIO_O),
    .mdio_oe(MDIO_OE),
    .phy_addr(PHY_ADDRESS),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data(rd_data)
  );

  // ==========================================================
  // Register state
  logic act_dis_q;
  logic link_dis_q;
  logic short_gap_idle_insert_q;
  logic isolate_q;
  logic serial_q;
  logic [15:0] test_q;
  logic [4:0] result_q;
  logic complete_q;
  logic ack_done_q;
  logic ack_seen_q;
  logic [2:0] pin_ff_q;
  logic pin_s_q;

  wire shadow_on = test_q[TEST_SHADOW_BIT];
  wire shadow_hit = shadow_on && in_shadow(reg_addr);
  wire hit_mode = (reg_addr == REG_AUX_MODE_LED_TXGAP) && !shadow_hit;
  wire hit_multi = (reg_addr == REG_AUX_MULTI_PHY_STATUS_CTRL) && !shadow_hit;
  wire hit_test = (reg_addr == REG_TEST_SHADOW_ENABLE);
  wire owned = hit_mode || hit_multi || hit_test;
  wire wr_mode = wr_stb && hit_mode;
  wire wr_multi = wr_stb && hit_multi;
  wire wr_test = wr_stb && hit_test;

  wire an_en = CTRL_AN_ENABLE && pin_s_q;
  wire restart = an_en && ((wr_multi && wr_data[MULTI_RESTART_BIT]) || CTRL_RESTART);
  wire ability = ABILITY_DETECT_STATE && an_en;
  wire serial_act = serial_q && !SPEED_100;

  wire [15:0] rd_mode = {11'h000, act_dis_q, link_dis_q, 1'b0, short_gap_idle_insert_q, 1'b0};
  // Restart bit position always reads zero
  wire [15:0] rd_multi = {result_q, 2'h0, 1'b0, complete_q, ack_done_q, ack_seen_q,
                          ability, isolate_q, 1'b0, serial_q, 1'b0};
  assign rd_data = hit_test ? test_q : hit_mode ? rd_mode : hit_multi ? rd_multi : EXT_RDATA;

  assign EXT_WR = wr_stb && !owned;
  assign EXT_RD = rd_stb && !owned;
  assign EXT_SHADOW = shadow_hit;
  assign EXT_ADDR = reg_addr;
  assign EXT_WDATA = wr_data;

  // Flags: a set in the same cycle as a restart or link fault wins; while disabled, complete and ack-done stay clear
  wire [4:0] result_d = (RESULT_VALID ? top_result(RESULT_MODE) : 5'h00) |
                        (result_q & ~{5{restart}});
  wire complete_d = (AN_DONE && an_en) ||
                    (complete_q && !restart && !LINK_FAULT && an_en);
  wire ack_done_d = (COMPLETE_ACK_EXIT && an_en) ||
                    (ack_done_q && !restart && !LINK_FAULT && an_en);
  wire ack_seen_d = ACK_DETECT_EXIT || (ack_seen_q && !restart);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pin_ff_q <= 3'h0;
      pin_s_q <= 1'b0;
      act_dis_q <= 1'b0;
      link_dis_q <= 1'b0;
      short_gap_idle_insert_q <= 1'b0;
      isolate_q <= 1'b0;
      serial_q <= 1'b0;
      test_q <= TEST_RESET;
      result_q <= 5'h00;
      complete_q <= 1'b0;
      ack_done_q <= 1'b0;
      ack_seen_q <= 1'b0;
      AN_RESTART <= 1'b0;
    end else begin
      pin_ff_q <= {pin_ff_q[1:0], NEGOTIATION_ENABLE_PIN};
      if (pin_ff_q[2] == pin_ff_q[1]) begin
        pin_s_q <= pin_ff_q[2];
      end
      if (wr_mode) begin
        act_dis_q <= wr_data[MODE_ACT_DIS_BIT];
        link_dis_q <= wr_data[MODE_LINK_DIS_BIT];
        short_gap_idle_insert_q <= wr_data[MODE_GAP_BIT];
      end
      if (wr_multi) begin
        isolate_q <= wr_data[MULTI_ISOLATE_BIT];
        serial_q <= wr_data[MULTI_SERIAL_BIT];
      end
      // Reserved bits are stored as written, so read-modify-write preserves them
      if (wr_test) begin
        test_q <= wr_data;
      end
      result_q <= result_d;
      complete_q <= complete_d;
      ack_done_q <= ack_done_d;
      ack_seen_q <= ack_seen_d;
      AN_RESTART <= restart;
    end
  end

  assign AN_ENABLED = an_en;

  // ==========================================================
  // Indicators and RMII datapath
  logic [2:0] gap_q;
  logic seen_pkt_q;
  logic tx_prev_q;
  wire tx_en_g = TX_EN_IN && !isolate_q;
  wire short_gap = (gap_q >= GAP_MIN) && (gap_q <= GAP_MAX);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      TRANSMIT_ACTIVITY_INDICATOR_N <= 1'b1;
      RECEIVE_ACTIVITY_INDICATOR_N <= 1'b1;
      LINK_INDICATOR_N <= 1'b1;
      TX_EN_CORE <= 1'b0;
      TXD_CORE <= 2'h0;
      CRS_DV_O <= 1'b0;
      RXD_O <= 2'h0;
      RMII_OE <= 1'b0;
      SERIAL_ACTIVE <= 1'b0;
      LINK_PULSE_EN <= 1'b0;
      INSERT_IDLES <= 1'b0;
      gap_q <= 3'h0;
      seen_pkt_q <= 1'b0;
      tx_prev_q <= 1'b0;
    end else begin
      TRANSMIT_ACTIVITY_INDICATOR_N <= act_dis_q || !TX_ACTIVITY;
      RECEIVE_ACTIVITY_INDICATOR_N <= act_dis_q || !RX_ACTIVITY;
      LINK_INDICATOR_N <= link_dis_q || !LINK_UP;
      TX_EN_CORE <= tx_en_g;
      TXD_CORE <= isolate_q ? 2'h0 : {TXD_IN[1] && !serial_act, TXD_IN[0]};
      CRS_DV_O <= CRS_DV_CORE && !isolate_q;
      RXD_O <= isolate_q ? 2'h0 : {RXD_CORE[1] && !serial_act, RXD_CORE[0]};
      RMII_OE <= !isolate_q;
      SERIAL_ACTIVE <= serial_act;
      LINK_PULSE_EN <= !isolate_q;
      tx_prev_q <= tx_en_g;
      if (tx_en_g) begin
        gap_q <= 3'h0;
        seen_pkt_q <= 1'b1;
      end else if (seen_pkt_q && gap_q != 3'h7) begin
        gap_q <= gap_q + 3'h1;
      end
      INSERT_IDLES <= short_gap_idle_insert_q && tx_en_g && !tx_prev_q &&
                      seen_pkt_q && short_gap;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  act_led_off_a: assert property (act_dis_q ##1 act_dis_q |->
    TRANSMIT_ACTIVITY_INDICATOR_N && RECEIVE_ACTIVITY_INDICATOR_N)
    else $error("activity indicator lit while disabled");
  link_led_off_a: assert property ($past(link_dis_q) |-> LINK_INDICATOR_N)
    else $error("link indicator lit while disabled");
  idle_insert_a: assert property (short_gap_idle_insert_q && tx_en_g && !tx_prev_q &&
    seen_pkt_q && short_gap |=> INSERT_IDLES)
    else $error("short gap without idle insertion");
  no_idle_long_a: assert property (tx_en_g && !tx_prev_q && (gap_q > GAP_MAX) |=>
    !INSERT_IDLES)
    else $error("idle insertion after long gap");
  first_pass_a: assert property (result_q == 5'h00 && RESULT_VALID &&
    RESULT_MODE != 5'h00 |=> $onehot(result_q))
    else $error("first pass result not one-hot");
  result_clear_a: assert property (restart && !RESULT_VALID |=> result_q == 5'h00)
    else $error("result bits survive restart");
  restart_pulse_a: assert property (wr_multi && wr_data[MULTI_RESTART_BIT] && an_en
    |=> AN_RESTART ##1 rd_multi[MULTI_RESTART_BIT] == 1'b0)
    else $error("restart write not acted on");
  // A completion in the same cycle as the restart wins, so it is left out here
  ctrl_restart_a: assert property (CTRL_RESTART && an_en && !AN_DONE && !RESULT_VALID |=>
    AN_RESTART && !complete_q && result_q == 5'h00)
    else $error("control restart not identical");
  complete_off_a: assert property (!an_en |=> !complete_q && !ack_done_q)
    else $error("complete flag set while disabled");
  ack_seen_hold_a: assert property (ack_seen_q && !restart |=> ack_seen_q)
    else $error("acknowledge detected dropped");
  ability_live_a: assert property (rd_multi[MULTI_ABILITY_BIT] ==
    (ABILITY_DETECT_STATE && an_en))
    else $error("ability bit mismatch");
  isolate_out_a: assert property ($past(isolate_q) |->
    !RMII_OE && !LINK_PULSE_EN && !TX_EN_CORE)
    else $error("isolate not applied");
  serial_speed_a: assert property (SPEED_100 |=> !SERIAL_ACTIVE)
    else $error("serial mode at hundred megabit");
  shadow_route_a: assert property (wr_stb && shadow_on && in_shadow(reg_addr) |->
    EXT_WR && EXT_SHADOW)
    else $error("shadow access not routed");

  restart_seen_c: cover property (restart ##[1:20] AN_DONE && an_en);
  multi_result_c: cover property (RESULT_VALID ##[1:50] RESULT_VALID && result_q != 5'h00);
  idle_insert_c: cover property (INSERT_IDLES);
  shadow_write_c: cover property (wr_stb && EXT_SHADOW);

endmodule

// *** testbench/mgmt_station_model.sv ***
// Management station model: drives serial management frames and collects read data
module mgmt_station_model
  import phy_aux_pkg::*;
#(
  parameter logic [4:0] STATION_PHY = 5'h01
)(
  // Clock
  input wire logic MCLK,
  // Management pins
  output logic MDC,
  output logic MDIO_I,
  input wire logic MDIO_O,
  input wire logic MDIO_OE
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_en = 1'h0;
  logic drv_bit = 1'h1;
  logic [15:0] rdata = 16'h0000;
  event done;

  // ==========================================================
  // Shared line
  // A released line floats up to the pull-up level, never holds the last bit
  assign MDIO_I = (drv_en ? drv_bit : 1'h1) & (MDIO_OE ? MDIO_O : 1'h1);

  initial begin
    MDC = 1'h0;
  end

  // Ten clock cycles per half period keeps well clear of the pin synchronisers
  task automatic half();
    repeat (10) @(posedge MCLK);
    #1;
  endtask

  // ==========================================================
  // Frame: preamble, start, op, addresses, turnaround, data
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, FRAME_START, op, STATION_PHY, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      drv_en = (op == OP_WRITE) || (i > 17);
      drv_bit = f[i];
      half();
      MDC = 1'h1;
      if (i < 16) begin
        rdata[i] = MDIO_I;
      end
      half();
      MDC = 1'h0;
    end
    drv_en = 1'h0;
    half();
    if (op == OP_READ) begin
      -> done;
    end
  endtask
endmodule

// *** testbench/phy_aux_control_status_regs_test.sv ***
// Self-checking bench for the auxiliary control and status registers
module phy_aux_control_status_regs_test
  import phy_aux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Design pins
  logic MCLK, NRST, MDC, MDIO_I, MDIO_O, MDIO_OE, EXT_WR, EXT_RD, EXT_SHADOW;
  logic [4:0] EXT_ADDR, RESULT_MODE;
  logic [15:0] EXT_WDATA, EXT_RDATA;
  logic NEGOTIATION_ENABLE_PIN, CTRL_AN_ENABLE, CTRL_RESTART, ABILITY_DETECT_STATE;
  logic ACK_DETECT_EXIT, COMPLETE_ACK_EXIT, AN_DONE, LINK_FAULT, RESULT_VALID;
  logic AN_ENABLED, AN_RESTART, TX_ACTIVITY, RX_ACTIVITY, LINK_UP;
  logic TRANSMIT_ACTIVITY_INDICATOR_N, RECEIVE_ACTIVITY_INDICATOR_N, LINK_INDICATOR_N;
  logic SPEED_100, TX_EN_IN, TX_EN_CORE, CRS_DV_CORE, CRS_DV_O, RMII_OE;
  logic SERIAL_ACTIVE, INSERT_IDLES, LINK_PULSE_EN;
  logic [1:0] TXD_IN, TXD_CORE, RXD_CORE, RXD_O;

  // ==========================================================
  // Bench state
  int seed = 30538;
  int compares = 0;
  int miscompares = 0;
  logic adis = 1'h0, ldis = 1'h0, iso = 1'h0, ser = 1'h0;
  logic [2:0] fl = 3'h0, rc_e = 3'h0, ic_e = 3'h0, rcount = 3'h0, icount = 3'h0;
  logic [4:0] res = 5'h00;
  logic [5:0] ext_e = 6'h00, ext_log = 6'h00;
  logic [15:0] reg_q[$];
  logic [24:0] pin_q[$];
  logic [24:0] got;
  logic [15:0] wd_log = 16'h0000;
  logic [15:0] wd_q[$];
  event snap, wsnap;

  phy_aux_control_status_regs #(.PHY_ADDRESS(5'h05)) u_phy_aux_control_status_regs (
    .MCLK, .NRST, .MDC, .MDIO_I, .MDIO_O, .MDIO_OE, .EXT_WR, .EXT_RD, .EXT_SHADOW,
    .EXT_ADDR, .EXT_WDATA, .EXT_RDATA, .NEGOTIATION_ENABLE_PIN, .CTRL_AN_ENABLE,
    .CTRL_RESTART, .ABILITY_DETECT_STATE, .ACK_DETECT_EXIT, .COMPLETE_ACK_EXIT, .AN_DONE,
    .LINK_FAULT, .RESULT_VALID, .RESULT_MODE, .AN_ENABLED, .AN_RESTART, .TX_ACTIVITY,
    .RX_ACTIVITY, .LINK_UP, .TRANSMIT_ACTIVITY_INDICATOR_N, .RECEIVE_ACTIVITY_INDICATOR_N,
    .LINK_INDICATOR_N, .SPEED_100, .TX_EN_IN, .TXD_IN, .TX_EN_CORE, .TXD_CORE,
    .CRS_DV_CORE, .RXD_CORE, .CRS_DV_O, .RXD_O, .RMII_OE, .SERIAL_ACTIVE, .INSERT_IDLES,
    .LINK_PULSE_EN
  );

  mgmt_station_model #(.STATION_PHY(5'h05)) u_mgmt_station_model (
    .MCLK, .MDC, .MDIO_I, .MDIO_O, .MDIO_OE
  );

  // ==========================================================
  // Observation
  assign got = {TRANSMIT_ACTIVITY_INDICATOR_N, RECEIVE_ACTIVITY_INDICATOR_N, LINK_INDICATOR_N,
    RMII_OE, LINK_PULSE_EN, SERIAL_ACTIVE, TX_EN_CORE, TXD_CORE, CRS_DV_O, RXD_O,
    AN_ENABLED, rcount, icount, ext_log};

  always @(posedge MCLK) begin
    if (AN_RESTART === 1'h1) rcount <= rcount + 3'h1;
    if (INSERT_IDLES === 1'h1) icount <= icount + 3'h1;
    if ((EXT_WR | EXT_RD) === 1'h1) ext_log <= {EXT_SHADOW, EXT_ADDR};
    if (EXT_WR === 1'h1) wd_log <= EXT_WDATA;
  end

  initial begin
    MCLK = 1'h0;
    forever #12.5 MCLK = ~MCLK;
  end

  initial begin
    #2400000;
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================
  // Expectations
  function automatic logic [24:0] want();
    logic s;
    s = ser & ~SPEED_100;
    want = {~(TX_ACTIVITY & ~adis), ~(RX_ACTIVITY & ~adis), ~(LINK_UP & ~ldis), ~iso, ~iso, s,
      TX_EN_IN & ~iso, TXD_IN[1] & ~iso & ~s, TXD_IN[0] & ~iso, CRS_DV_CORE & ~iso,
      RXD_CORE[1] & ~iso & ~s, RXD_CORE[0] & ~iso, CTRL_AN_ENABLE & NEGOTIATION_ENABLE_PIN,
      rc_e, ic_e, ext_e};
  endfunction

  function automatic logic [15:0] e1e();
    logic ab;
    ab = ABILITY_DETECT_STATE & CTRL_AN_ENABLE & NEGOTIATION_ENABLE_PIN;
    e1e = {res, 3'h0, fl, ab, iso, 1'h0, ser, 1'h0};
  endfunction

  // ==========================================================
  // Comparison
  task automatic tally(input logic [24:0] e, input logic [24:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic compare_reg(input logic [15:0] e, input logic [15:0] g);
    tally({9'h000, e}, {9'h000, g});
  endtask

  task automatic compare_pins(input logic [24:0] e, input logic [24:0] g);
    tally(e, g);
  endtask

  initial forever begin
    @(u_mgmt_station_model.done);
    compare_reg(reg_q.pop_front(), u_mgmt_station_model.rdata);
  end

  initial forever begin
    @(snap);
    compare_pins(pin_q.pop_front(), got);
  end

  initial forever begin
    @(wsnap);
    compare_reg(wd_q.pop_front(), wd_log);
  end

  // ==========================================================
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_mgmt_station_model.xfer(OP_WRITE, ra, d);
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    reg_q.push_back(e);
    u_mgmt_station_model.xfer(OP_READ, ra, 16'h0000);
  endtask

  task automatic chk();
    cyc(4);
    pin_q.push_back(want());
    -> snap;
  endtask

  task automatic rnd();
    {TX_ACTIVITY, RX_ACTIVITY, LINK_UP, TX_EN_IN, TXD_IN, CRS_DV_CORE, RXD_CORE, SPEED_100} =
      10'($random(seed));
  endtask

  task automatic pulse(input logic [5:0] v);
    {LINK_FAULT, RESULT_VALID, AN_DONE, COMPLETE_ACK_EXIT, ACK_DETECT_EXIT, CTRL_RESTART} = v;
    cyc(1);
    {LINK_FAULT, RESULT_VALID, AN_DONE, COMPLETE_ACK_EXIT, ACK_DETECT_EXIT, CTRL_RESTART} = 6'h00;
    cyc(3);
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    NRST = 1'h0;
    rnd();
    {LINK_FAULT, RESULT_VALID, AN_DONE, COMPLETE_ACK_EXIT, ACK_DETECT_EXIT, CTRL_RESTART} = 6'h00;
    {ABILITY_DETECT_STATE, RESULT_MODE, EXT_RDATA} = 22'h000000;
    {CTRL_AN_ENABLE, NEGOTIATION_ENABLE_PIN} = 2'h3;
    repeat (12) @(posedge MCLK);
    #1;
    NRST = 1'h1;
    cyc(10);
    rd(REG_AUX_MODE_LED_TXGAP, 16'h0000);
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, 16'h0000);
    rd(REG_TEST_SHADOW_ENABLE, TEST_RESET);
    for (int k = 0; k < 4; k++) begin
      {adis, ldis} = 2'(k);
      wr(REG_AUX_MODE_LED_TXGAP, {11'h000, adis, ldis, 3'h0});
      rd(REG_AUX_MODE_LED_TXGAP, {11'h000, adis, ldis, 3'h0});
      rnd();
      chk();
    end
    // Isolate and serial combinations, ending with both off
    for (int k = 3; k >= 0; k--) begin
      {iso, ser} = 2'(k);
      wr(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
      rnd();
      chk();
      rnd();
      chk();
      rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    end
    // Negotiation progress flags and results
    RESULT_MODE = 5'h16;
    pulse(6'h02);
    pulse(6'h04);
    pulse(6'h08);
    pulse(6'h10);
    {res, fl} = {5'h10, 3'h7};
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    pulse(6'h20);
    fl = 3'h1;
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    RESULT_MODE = 5'h03;
    pulse(6'h10);
    res = 5'h12;
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    wr(REG_AUX_MULTI_PHY_STATUS_CTRL, 16'h0100);
    {res, fl, rc_e} = {8'h00, rc_e + 3'h1};
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    chk();
    RESULT_MODE = 5'h09;
    pulse(6'h12);
    {res, fl} = {5'h08, 3'h1};
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    pulse(6'h01);
    {res, fl, rc_e} = {8'h00, rc_e + 3'h1};
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    pulse(6'h02);
    fl = 3'h1;
    ABILITY_DETECT_STATE = 1'h1;
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    NEGOTIATION_ENABLE_PIN = 1'h0;
    cyc(8);
    wr(REG_AUX_MULTI_PHY_STATUS_CTRL, 16'h0100);
    pulse(6'h01);
    rd(REG_AUX_MULTI_PHY_STATUS_CTRL, e1e());
    chk();
    {NEGOTIATION_ENABLE_PIN, ABILITY_DETECT_STATE} = 2'h2;
    // Shadow bank steering; reserved bits kept by read-modify-write
    EXT_RDATA = 16'($random(seed));
    wr(REG_TEST_SHADOW_ENABLE, TEST_RESET | 16'h0080);
    rd(REG_TEST_SHADOW_ENABLE, TEST_RESET | 16'h0080);
    wr(SHADOW_ADDR_LO, 16'($random(seed)));
    ext_e = {1'h1, SHADOW_ADDR_LO};
    chk();
    rd(SHADOW_ADDR_LO + 5'h01, EXT_RDATA);
    wr(REG_TEST_SHADOW_ENABLE, TEST_RESET);
    wr(SHADOW_ADDR_LO, 16'h1234);
    wd_q.push_back(16'h1234);
    -> wsnap;
    ext_e = {1'h0, SHADOW_ADDR_LO};
    chk();
    rd(5'h05, EXT_RDATA);
    ext_e = {1'h0, 5'h05};
    // Short gaps of one to six cycles; only one to four insert idles
    wr(REG_AUX_MODE_LED_TXGAP, 16'h0002);
    {adis, ldis} = 2'h0;
    TX_EN_IN = 1'h0;
    cyc(8);
    for (int g = 1; g <= 6; g++) begin
      TX_EN_IN = 1'h1;
      cyc(3);
      TX_EN_IN = 1'h0;
      cyc(g);
    end
    wr(REG_AUX_MODE_LED_TXGAP, 16'h0000);
    TX_EN_IN = 1'h1;
    cyc(3);
    TX_EN_IN = 1'h0;
    cyc(2);
    TX_EN_IN = 1'h1;
    ic_e = 3'h4;
    chk();
    tally_and_finish();
  end
endmodule
